//--- verilog/pulse_chop_float_sequencer.sv
/*
  Per-slot pulse sequencer: chop/float patterns, connection modulation and
  signed accumulation, with an AXI4-Lite register slave.
  Assumes the front end answers each pulse with one adc_valid_i strobe.
*/
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pulse_chop_float_sequencer #(
  parameter int unsigned NUM_SLOTS = 12,
  parameter int unsigned ADC_W     = 14,
  parameter int unsigned ACC_W     = 24
) (
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    adc_valid_i,
  input  wire logic signed [ADC_W-1:0] adc_data_i,
  output pulse_seq_pkg::front_ctl_t    front_ctl_o,
  output logic                         result_valid_o,
  output logic [ACC_W-1:0]             result_o
);
  localparam int unsigned SLOT_W = 4;

  typedef struct packed {
    logic [NUM_SLOTS-1:0][15:0] pat;
    logic [NUM_SLOTS-1:0][7:0]  rep;
    logic                       awready;
    logic                       wready;
    logic                       aw_got;
    logic                       w_got;
    logic [9:0]                 aw_idx;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    pulse_seq_pkg::seq_state_t  state;
    logic [SLOT_W-1:0]          slot;
    logic [15:0]                cfg;
    logic [7:0]                 total;
    logic [7:0]                 idx;
    logic [7:0]                 timer;
    logic signed [ACC_W-1:0]    acc;
    logic                       done;
    pulse_seq_pkg::front_ctl_t  ctl;
    logic                       res_valid;
    logic [ACC_W-1:0]           result;
  } state_t;

  state_t st;
  state_t next_st;

  initial begin
    if (NUM_SLOTS < 1 || NUM_SLOTS > 16 || ADC_W < 2 || ACC_W < ADC_W + 9 || ACC_W > 32) begin
      $error("pulse_chop_float_sequencer: unsupported parameters");
    end
  end

  logic [9:0]                 w_idx;
  logic [9:0]                 r_idx;
  logic                       do_write;
  logic                       aw_take;
  logic                       w_take;
  logic [31:0]                wd;
  logic [3:0]                 ws;
  logic                       start_req;
  logic                       done_clr;
  logic signed [ACC_W-1:0]    adc_ext;
  logic [1:0]                 pos;
  logic [1:0]                 next_pos;
  pulse_seq_pkg::mod_t        mode;

  assign adc_ext = ACC_W'(adc_data_i);
  assign pos     = st.idx[1:0];
  assign mode    = pulse_seq_pkg::mod_t'(st.cfg[pulse_seq_pkg::MOD_LSB +: 2]);

  always_comb begin
    next_st   = st;
    aw_take   = s_axi_awvalid && st.awready;
    w_take    = s_axi_wvalid && st.wready;
    w_idx     = st.aw_got ? st.aw_idx : s_axi_awaddr[11:2];
    wd        = st.w_got ? st.wdata : s_axi_wdata;
    ws        = st.w_got ? st.wstrb : s_axi_wstrb;
    do_write  = (st.aw_got || aw_take) && (st.w_got || w_take) && !st.bvalid;
    r_idx     = s_axi_araddr[11:2];
    start_req = 1'b0;
    done_clr  = 1'b0;
    next_pos  = 2'h0;
    if (aw_take) begin
      next_st.aw_got = 1'b1;
      next_st.aw_idx = s_axi_awaddr[11:2];
    end
    if (w_take) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = pulse_seq_pkg::RESP_SLVERR;
      for (int s = 0; s < NUM_SLOTS; s++) begin
        if (w_idx == pulse_seq_pkg::PAT_IDX + 10'(s) * pulse_seq_pkg::SLOT_STRIDE) begin
          next_st.bresp = pulse_seq_pkg::RESP_OKAY;
          if (ws[0]) next_st.pat[s][7:0] = wd[7:0];
          if (ws[1]) next_st.pat[s][15:8] = wd[15:8];
        end
        if (w_idx == pulse_seq_pkg::REP_IDX + 10'(s) * pulse_seq_pkg::SLOT_STRIDE) begin
          next_st.bresp = pulse_seq_pkg::RESP_OKAY;
          if (ws[0]) next_st.rep[s] = wd[7:0];
        end
      end
      if (w_idx == pulse_seq_pkg::CMD_IDX) begin
        next_st.bresp = pulse_seq_pkg::RESP_OKAY;
        start_req     = ws[0] && wd[pulse_seq_pkg::START_BIT];
      end
      if (w_idx == pulse_seq_pkg::STAT_IDX) begin
        next_st.bresp = pulse_seq_pkg::RESP_OKAY;
        done_clr      = ws[0] && wd[pulse_seq_pkg::DONE_BIT];
      end
      if (w_idx == pulse_seq_pkg::RES_IDX) begin
        next_st.bresp = pulse_seq_pkg::RESP_OKAY;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready  = !next_st.w_got && !next_st.bvalid;

    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = 32'h00000000;
      next_st.rresp  = pulse_seq_pkg::RESP_SLVERR;
      for (int s = 0; s < NUM_SLOTS; s++) begin
        if (r_idx == pulse_seq_pkg::PAT_IDX + 10'(s) * pulse_seq_pkg::SLOT_STRIDE) begin
          next_st.rdata = {16'h0000, st.pat[s]};
          next_st.rresp = pulse_seq_pkg::RESP_OKAY;
        end
        if (r_idx == pulse_seq_pkg::REP_IDX + 10'(s) * pulse_seq_pkg::SLOT_STRIDE) begin
          next_st.rdata = {24'h000000, st.rep[s]};
          next_st.rresp = pulse_seq_pkg::RESP_OKAY;
        end
      end
      if (r_idx == pulse_seq_pkg::CMD_IDX) begin
        next_st.rdata = {24'h000000, st.slot, 4'h0};
        next_st.rresp = pulse_seq_pkg::RESP_OKAY;
      end
      if (r_idx == pulse_seq_pkg::STAT_IDX) begin
        next_st.rdata = {30'h00000000, st.done, st.state != pulse_seq_pkg::ST_IDLE};
        next_st.rresp = pulse_seq_pkg::RESP_OKAY;
      end
      if (r_idx == pulse_seq_pkg::RES_IDX) begin
        next_st.rdata = 32'(st.result);
        next_st.rresp = pulse_seq_pkg::RESP_OKAY;
      end
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;

    // Sequencer; a start while busy is ignored
    next_st.res_valid = 1'b0;
    case (st.state)
      pulse_seq_pkg::ST_IDLE: begin
        if (start_req) begin
          next_st.slot  = wd[pulse_seq_pkg::SLOT_LSB +: SLOT_W];
          next_st.cfg   = st.pat[wd[pulse_seq_pkg::SLOT_LSB +: SLOT_W]];
          next_st.total = st.rep[wd[pulse_seq_pkg::SLOT_LSB +: SLOT_W]];
          if (next_st.total == 8'h00) next_st.total = 8'h01;
          next_st.idx   = 8'h00;
          next_st.acc   = '0;
          next_st.timer = 8'(pulse_seq_pkg::PRECON_CYC);
          next_st.state = pulse_seq_pkg::ST_PRECON;
        end
      end
      pulse_seq_pkg::ST_PRECON: begin
        next_st.timer = st.timer - 8'h01;
        if (st.timer == 8'h01) begin
          if (mode == pulse_seq_pkg::MOD_FLOAT) begin
            next_st.timer = 8'(pulse_seq_pkg::FLOAT_CYC);
            next_st.state = pulse_seq_pkg::ST_GAP;
          end else begin
            next_st.state = pulse_seq_pkg::ST_PULSE;
          end
        end
      end
      pulse_seq_pkg::ST_GAP: begin
        next_st.timer = st.timer - 8'h01;
        if (st.timer == 8'h01) begin
          next_st.state = pulse_seq_pkg::ST_PULSE;
        end
      end
      pulse_seq_pkg::ST_PULSE: begin
        if (adc_valid_i) begin
          if (st.cfg[pulse_seq_pkg::SIGN_LSB + 32'(pos)]) begin
            next_st.acc = st.acc - adc_ext;
          end else begin
            next_st.acc = st.acc + adc_ext;
          end
          next_st.idx = st.idx + 8'h01;
          if (st.idx + 8'h01 == st.total) begin
            next_st.state = pulse_seq_pkg::ST_STORE;
          end else if (mode == pulse_seq_pkg::MOD_CONT) begin
            next_st.state = pulse_seq_pkg::ST_PULSE;
          end else begin
            next_st.timer = 8'(pulse_seq_pkg::FLOAT_CYC);
            next_st.state = pulse_seq_pkg::ST_GAP;
          end
        end
      end
      pulse_seq_pkg::ST_STORE: begin
        next_st.result    = st.cfg[pulse_seq_pkg::BIAS_BIT] ? ACC_W'(st.acc) + ACC_W'(pulse_seq_pkg::MID_CODE)
                                                            : ACC_W'(st.acc);
        next_st.res_valid = 1'b1;
        next_st.state     = pulse_seq_pkg::ST_IDLE;
      end
      default: begin
        next_st.state = pulse_seq_pkg::ST_IDLE;
      end
    endcase
    // Done is sticky; a completion in the clearing cycle wins
    if (done_clr) next_st.done = 1'b0;
    if (st.state == pulse_seq_pkg::ST_STORE) next_st.done = 1'b1;

    // Front-end controls follow the state being entered
    next_pos = next_st.idx[1:0];
    next_st.ctl = '0;
    next_st.ctl.bandpass_bypass = (next_st.state != pulse_seq_pkg::ST_IDLE) &&
                                  (next_st.cfg[pulse_seq_pkg::MOD_LSB +: 2] == 2'(pulse_seq_pkg::MOD_FLOAT));
    case (next_st.state)
      pulse_seq_pkg::ST_PRECON: begin
        next_st.ctl.precon_tie = 1'b1;
      end
      pulse_seq_pkg::ST_GAP: begin
        // Float leaves the input open; nonfloat holds the precondition level
        next_st.ctl.precon_tie = next_st.cfg[pulse_seq_pkg::MOD_LSB +: 2] == 2'(pulse_seq_pkg::MOD_NONFLOAT);
      end
      pulse_seq_pkg::ST_PULSE: begin
        next_st.ctl.pulse    = 1'b1;
        next_st.ctl.connect  = 1'b1;
        next_st.ctl.led_fire = !next_st.cfg[pulse_seq_pkg::MASK_LSB + 32'(next_pos)];
        // Float keeps normal order so the charge lands in the negative phase
        next_st.ctl.integ_reverse = next_st.ctl.bandpass_bypass ? 1'b0
                                    : next_st.cfg[pulse_seq_pkg::REV_LSB + 32'(next_pos)];
      end
      default: begin
        next_st.ctl.pulse = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st       <= '0;
      st.pat   <= {NUM_SLOTS{pulse_seq_pkg::PAT_RESET}};
      st.rep   <= {NUM_SLOTS{pulse_seq_pkg::REP_RESET}};
      st.state <= pulse_seq_pkg::ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready  = st.awready;
  assign s_axi_wready   = st.wready;
  assign s_axi_bvalid   = st.bvalid;
  assign s_axi_bresp    = st.bresp;
  assign s_axi_arready  = st.arready;
  assign s_axi_rvalid   = st.rvalid;
  assign s_axi_rdata    = st.rdata;
  assign s_axi_rresp    = st.rresp;
  assign front_ctl_o    = st.ctl;
  assign result_valid_o = st.res_valid;
  assign result_o       = st.result;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sign_subtract_a: assert property (
    st.state == pulse_seq_pkg::ST_PULSE && adc_valid_i && st.cfg[pulse_seq_pkg::SIGN_LSB + 32'(pos)]
    |=> st.acc == $past(st.acc) - $past(adc_ext))
    else $error("subtracted pulse not taken off");
  sign_add_a: assert property (
    st.state == pulse_seq_pkg::ST_PULSE && adc_valid_i && !st.cfg[pulse_seq_pkg::SIGN_LSB + 32'(pos)]
    |=> st.acc == $past(st.acc) + $past(adc_ext))
    else $error("added pulse not summed");
  reverse_bit_a: assert property (
    st.state == pulse_seq_pkg::ST_PULSE && mode != pulse_seq_pkg::MOD_FLOAT
    |-> st.ctl.integ_reverse == st.cfg[pulse_seq_pkg::REV_LSB + 32'(pos)])
    else $error("integrator reverse wrong for position");
  led_mask_a: assert property (
    st.state == pulse_seq_pkg::ST_PULSE |-> st.ctl.led_fire == !st.cfg[pulse_seq_pkg::MASK_LSB + 32'(pos)])
    else $error("led fire disagrees with mask");
  cont_connect_a: assert property (
    mode == pulse_seq_pkg::MOD_CONT && st.state == pulse_seq_pkg::ST_PRECON ##1 st.state != pulse_seq_pkg::ST_PRECON
    |-> st.ctl.connect && st.state != pulse_seq_pkg::ST_GAP)
    else $error("continuous mode lost connection");
  float_gap_a: assert property (
    st.state == pulse_seq_pkg::ST_GAP && mode == pulse_seq_pkg::MOD_FLOAT |-> !st.ctl.connect && !st.ctl.precon_tie)
    else $error("float gap not floating");
  nonfloat_tie_a: assert property (
    st.state == pulse_seq_pkg::ST_GAP && mode == pulse_seq_pkg::MOD_NONFLOAT |-> !st.ctl.connect && st.ctl.precon_tie)
    else $error("nonfloat gap not tied");
  float_bypass_a: assert property (
    st.state != pulse_seq_pkg::ST_IDLE && mode == pulse_seq_pkg::MOD_FLOAT |-> st.ctl.bandpass_bypass)
    else $error("float mode kept bandpass filter");
  float_sequence_a: assert property (
    st.state == pulse_seq_pkg::ST_PRECON && mode == pulse_seq_pkg::MOD_FLOAT && st.timer == 8'h01
    |=> st.state == pulse_seq_pkg::ST_GAP && !st.ctl.connect)
    else $error("float mode skipped float time");
  single_write_a: assert property (
    result_valid_o |-> $past(st.state) == pulse_seq_pkg::ST_STORE && $past(st.idx) == $past(st.total) ##1 !result_valid_o)
    else $error("result written other than once");
  bias_add_a: assert property (
    st.state == pulse_seq_pkg::ST_STORE && st.cfg[pulse_seq_pkg::BIAS_BIT]
    |=> result_o == ACC_W'($past(st.acc)) + ACC_W'(pulse_seq_pkg::MID_CODE))
    else $error("mid-code bias missing");

  chop_done_c: cover property (result_valid_o && st.cfg[7:4] == 4'hA && st.cfg[3:0] == 4'hA);
  float_done_c: cover property (result_valid_o && mode == pulse_seq_pkg::MOD_FLOAT);
  nonfloat_gap_c: cover property (st.state == pulse_seq_pkg::ST_GAP && mode == pulse_seq_pkg::MOD_NONFLOAT);
endmodule
`default_nettype wire

//--- pkg/pulse_seq_pkg.sv
/*
  Constants, types and register map of the pulse chop/float sequencer.
  Assumes a 10 MHz clock and register indices (byte address = 4 x index).
*/
// Overview of operation
// - Chop inverts integration for half the pulses
// - Inverted pulses subtracted, normal pulses added
// - Four-bit patterns repeat every four pulses
// - Sign bit set subtracts that pulse position
// - Reverse bit swaps integration phase order
// - Pattern 0xA inverts and subtracts pulses 2,4
// - Mid-code bias adds 2048 to result
// - Slot registers repeat every 0x020 index
// - Select 0 keeps amplifier continuously connected
// - Select 1 floats input between pulses
// - Select 2 ties input to precondition between
// - Float: precondition, float time, then reconnect
// - Float mode bypasses the bandpass filter
// - Float charge lands in negative phase
// - Float LED pairs lit and dark, subtracted
// - LED mask repeats per four-pulse group
// - Repeat count sets total pulses per sample
// - Exactly one result write per sample
package pulse_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned PRECON_TIME_NS = 2000;
  localparam int unsigned FLOAT_TIME_NS  = 4000;
  localparam int unsigned PRECON_CYC     = (PRECON_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLOAT_CYC      = (FLOAT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [9:0]  PAT_IDX     = 10'h10D;
  localparam logic [9:0]  REP_IDX     = 10'h107;
  localparam logic [9:0]  SLOT_STRIDE = 10'h020;
  localparam logic [9:0]  CMD_IDX     = 10'h0F0;
  localparam logic [9:0]  STAT_IDX    = 10'h0F1;
  localparam logic [9:0]  RES_IDX     = 10'h0F2;

  localparam int unsigned SIGN_LSB = 0;
  localparam int unsigned REV_LSB  = 4;
  localparam int unsigned MASK_LSB = 8;
  localparam int unsigned MOD_LSB  = 12;
  localparam int unsigned BIAS_BIT = 14;
  localparam int unsigned START_BIT = 0;
  localparam int unsigned SLOT_LSB  = 4;
  localparam int unsigned BUSY_BIT  = 0;
  localparam int unsigned DONE_BIT  = 1;

  localparam logic [15:0] PAT_RESET = 16'h0000;
  localparam logic [7:0]  REP_RESET = 8'h01;
  localparam logic [23:0] MID_CODE  = 24'h000800;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_PRECON = 3'h1,
    ST_GAP    = 3'h3,
    ST_PULSE  = 3'h2,
    ST_STORE  = 3'h6
  } seq_state_t;

  typedef enum logic [1:0] {
    MOD_CONT     = 2'h0,
    MOD_FLOAT    = 2'h1,
    MOD_NONFLOAT = 2'h2
  } mod_t;

  typedef struct packed {
    logic pulse;
    logic integ_reverse;
    logic led_fire;
    logic connect;
    logic precon_tie;
    logic bandpass_bypass;
  } front_ctl_t;
endpackage

//--- verification/front_end_model.sv
/*
  Behavioural photodiode, LED and ADC front end facing the sequencer.
  Assumes one adc strobe is wanted per sequencer pulse; delay_i sets how slowly it answers.
*/
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  input  wire logic                      clock_i,
  input  wire logic                      rst_n_i,
  input  wire pulse_seq_pkg::front_ctl_t front_ctl_i,
  input  wire logic [7:0]                delay_i,
  output logic                           adc_valid_o,
  output logic signed [13:0]             adc_data_o
);
  logic [7:0] wait_cnt;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adc_valid_o <= 1'b0;
      adc_data_o  <= 14'h0000;
      wait_cnt    <= 8'h00;
    end else if (front_ctl_i.pulse && !adc_valid_o && wait_cnt == delay_i) begin
      adc_valid_o <= 1'b1;
      // Lit pulse carries more charge; reversed integration flips the sign
      adc_data_o  <= front_ctl_i.led_fire ? (front_ctl_i.integ_reverse ? 14'h3F9C : 14'h0064)
                                          : (front_ctl_i.integ_reverse ? 14'h3FF6 : 14'h000A);
      wait_cnt    <= 8'h00;
    end else begin
      adc_valid_o <= 1'b0;
      // Stale data must never look valid
      adc_data_o  <= ~adc_data_o;
      wait_cnt    <= !front_ctl_i.pulse ? 8'h00 : wait_cnt + 8'(wait_cnt != delay_i);
    end
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
/*
  Self-checking bench: AXI4-Lite register tasks and per-slot sample runs.
  Assumes the front end model answers every pulse with one adc strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                      clock_i, rst_n_i, adc_valid_i, result_valid_o;
  logic [11:0]               s_axi_awaddr, s_axi_araddr;
  logic                      s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                      s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                      s_axi_rvalid, s_axi_rready;
  logic [31:0]               s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]                s_axi_wstrb;
  logic [1:0]                s_axi_bresp, s_axi_rresp, resp, mode;
  logic signed [13:0]        adc_data_i;
  logic [23:0]               result_o;
  pulse_seq_pkg::front_ctl_t front_ctl_o;
  logic [7:0]                delay;
  logic [15:0]               cur_pat;
  int                        n_mismatch, check_count, pulse_k, rep_n, gap_cnt, rv_count, b;

  pulse_chop_float_sequencer i_dut (.clock_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .adc_valid_i, .adc_data_i, .front_ctl_o, .result_valid_o, .result_o);
  front_end_model i_model (.clock_i, .rst_n_i, .front_ctl_i(front_ctl_o), .delay_i(delay),
    .adc_valid_o(adc_valid_i), .adc_data_o(adc_data_i));

  always #50 clock_i = ~clock_i;

  task check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task final_report;
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task axi_write(input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge clock_i);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        resp = s_axi_bresp;
        break;
      end
    end
    // A response that never comes is a failure, not a silent skip
    if (t == 100) n_mismatch++;
    s_axi_bready <= 1'b0;
  endtask

  task axi_read(input logic [11:0] a);
    int t;
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge clock_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        break;
      end
    end
    if (t == 100) n_mismatch++;
    s_axi_rready <= 1'b0;
  endtask

  task rd_chk(input logic [9:0] idx, input logic [31:0] want);
    axi_read({idx, 2'b00});
    check(rd, want);
    check(resp, pulse_seq_pkg::RESP_OKAY);
  endtask

  function logic [23:0] exp_res(input logic [15:0] p, input int rep);
    int acc, v, k4;
    acc = p[14] ? 2048 : 0;
    for (int k = 0; k < rep; k++) begin
      k4 = k % 4;
      v = p[8+k4] ? 10 : 100;
      if (p[4+k4] && p[13:12] != 2'h1) v = -v;
      acc = p[k4] ? acc - v : acc + v;
    end
    return acc[23:0];
  endfunction

  // Pulse-by-pulse view of the front end controls
  always @(posedge clock_i) begin
    if (result_valid_o === 1'b1) rv_count++;
    mode = cur_pat[13:12];
    if (adc_valid_i === 1'b1 && front_ctl_o.pulse === 1'b1) begin
      b = pulse_k % 4;
      check(front_ctl_o.integ_reverse, mode != 2'h1 && cur_pat[4+b]);
      check(front_ctl_o.led_fire, !cur_pat[8+b]);
      check(front_ctl_o.connect, 1'b1);
      check(front_ctl_o.bandpass_bypass, mode == 2'h1);
      pulse_k++;
      gap_cnt = pulse_k < rep_n ? 10 : 0;
    end else if (gap_cnt > 0) begin
      gap_cnt--;
      if (gap_cnt == 0) begin
        check(front_ctl_o.connect, mode == 2'h0);
        check(front_ctl_o.precon_tie, mode == 2'h2);
      end
    end
  end

  task run(input int slot, input logic [15:0] pat, input int rep, input logic [7:0] dly);
    logic [9:0]  off;
    logic [23:0] want;
    int          t;
    off = pulse_seq_pkg::SLOT_STRIDE * 10'(slot);
    want = exp_res(pat, rep);
    axi_write({pulse_seq_pkg::PAT_IDX + off, 2'b00}, {16'h0000, pat});
    check(resp, pulse_seq_pkg::RESP_OKAY);
    axi_write({pulse_seq_pkg::REP_IDX + off, 2'b00}, 32'(rep));
    cur_pat = pat;
    rep_n = rep;
    pulse_k = 0;
    rv_count = 0;
    delay <= dly;
    axi_write({pulse_seq_pkg::CMD_IDX, 2'b00}, 32'(slot * 16 + 1));
    repeat (5) @(posedge clock_i);
    check(front_ctl_o.precon_tie, 1'b1);
    // Still inside preconditioning, so busy and not yet done
    rd_chk(pulse_seq_pkg::STAT_IDX, 32'h0000_0001);
    for (t = 0; t < 3000; t++) begin
      @(posedge clock_i);
      if (result_valid_o === 1'b1) break;
    end
    if (t == 3000) n_mismatch++;
    check(result_o, want);
    repeat (20) @(posedge clock_i);
    check(rv_count, 1);
    check(pulse_k, rep);
    axi_read({pulse_seq_pkg::RES_IDX, 2'b00});
    check(rd[23:0], want);
    rd_chk(pulse_seq_pkg::STAT_IDX, 32'h0000_0002);
    axi_write({pulse_seq_pkg::STAT_IDX, 2'b00}, 32'h0000_0002);
    rd_chk(pulse_seq_pkg::STAT_IDX, 32'h0000_0000);
    rd_chk(pulse_seq_pkg::CMD_IDX, 32'(slot * 16));
  endtask

  initial begin
    clock_i = 1'b0;
    rst_n_i = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    delay = 8'h00;
    cur_pat = 16'h0000;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd_chk(pulse_seq_pkg::PAT_IDX, 32'h0000_0000);
    rd_chk(pulse_seq_pkg::REP_IDX, 32'h0000_0001);
    rd_chk(pulse_seq_pkg::STAT_IDX, 32'h0000_0000);
    axi_read(12'h000);
    check(rd, 32'h0000_0000);
    check(resp, pulse_seq_pkg::RESP_SLVERR);
    axi_write(12'h000, 32'h0000_0001);
    check(resp, pulse_seq_pkg::RESP_SLVERR);
    axi_write({pulse_seq_pkg::PAT_IDX + 10'h060, 2'b00}, 32'h0000_6A5A);
    rd_chk(pulse_seq_pkg::PAT_IDX + 10'h060, 32'h0000_6A5A);
    // Slow answers make the gap check land inside a continuous pulse
    run(0, 16'h0003, 5, 8'h0C);
    run(0, 16'h00AA, 6, 8'h00);
    run(2, 16'h59F9, 4, 8'h03);
    run(1, 16'h2A05, 8, 8'h01);
    final_report;
  end

  initial begin
    #2_000_000;
    n_mismatch++;
    final_report;
  end
endmodule
`default_nettype wire
